// file: sfpe_front_end.sv
// Serial flash pin front end: lane shifter on the serial clock, system side
`timescale 1ns/1ps
`default_nettype none
module sfpe_front_end
   import sfpe_pkg::*;
#(
   parameter int   ARRAY_AW      = 24,
   parameter logic HAS_RESET_PIN = 1'b0
) (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_spi_clk,
   input  wire logic       i_cs_b,
   input  wire logic [3:0] i_lane_in,
   output logic [3:0]      o_lane_out,
   output logic [3:0]      o_lane_oe,
   input  wire logic       i_reset_pin_b,
   input  wire logic       i_quad_enable_bit,
   input  wire logic       i_hold_reset_sel,
   input  wire logic [1:0] i_status_protect_bits,
   input  wire logic       i_block_protect_2,
   input  wire logic       i_block_protect_1,
   input  wire logic       i_block_protect_0,
   input  wire logic       i_protect_top_bottom,
   input  wire logic       i_protect_sector_granularity,
   input  wire logic       i_protect_complement,
   input  wire logic       i_tx_valid,
   output logic            o_tx_ready,
   input  wire logic [7:0] i_tx_data,
   output logic            o_rx_valid,
   input  wire logic       i_rx_ready,
   output logic [7:0]      o_rx_data,
   output logic            o_rx_first,
   output logic            o_selected,
   output logic            o_armed,
   output logic            o_pin_reset,
   output logic            o_rx_overrun,
   input  wire logic       i_clear_overrun,
   output logic            o_status_write_block,
   output logic            o_addr_protected
);

   // Link-side declarations
   logic        armed_q;
   logic        cfg_qe_q;
   logic        cfg_hsel_q;
   logic        hold_fn;
   logic        pin_rst;
   logic        frame_rst_b;
   logic        pause_q;
   logic        pause;
   sfpe_state_t st_q;
   logic [7:0]  sr_q;
   logic [7:0]  sr_d;
   logic [3:0]  bcnt_q;
   logic [3:0]  lw_q;
   logic [3:0]  ow_q;
   logic [1:0]  acnt_q;
   logic [3:0]  dcnt_q;
   logic        shifting;
   logic        byte_done;
   logic [8:0]  rx_mem_q [2];
   logic [1:0]  rx_wp_q;
   logic [1:0]  rx_rp_s1_q, rx_rp_s2_q, rx_rp_s3_q, rx_rps_q;
   logic        rx_full;
   logic        rx_push;
   logic        ovf_tog_q;
   logic [3:0]  out_q;
   logic [7:0]  tsr_q;
   logic [3:0]  ocnt_q;
   logic        oact_q;
   logic        drain;
   logic        tx_pop;
   logic        tx_empty_l;
   logic [1:0]  tx_rp_q;
   logic [1:0]  tx_wp_s1_q, tx_wp_s2_q, tx_wp_s3_q, tx_wps_q;
   // System-side declarations
   logic [7:0]  tx_mem_q [2];
   logic [1:0]  tx_wp_q;
   logic [1:0]  tx_rp_s1_q, tx_rp_s2_q, tx_rp_s3_q, tx_rps_q;
   logic        tx_full;
   logic        txf_valid;
   logic [7:0]  txf_data;
   logic        tx_put;
   logic [1:0]  rx_rp_q;
   logic [1:0]  rx_wp_s1_q, rx_wp_s2_q, rx_wp_s3_q, rx_wps_q;
   logic        rx_empty;
   logic        rxf_ready;
   logic        rx_take;
   logic [8:0]  rx_word;
   logic [8:0]  rxf_out;
   logic [4:0]  sy_s1_q, sy_s2_q, sy_s3_q, sy_q;
   logic        ovf_prev_q;
   logic        ovf_event;
   logic        ovr_q;
   logic        swb_q;
   logic        prot_q;
   logic [1:0]  aidx_q;
   logic [ARRAY_AW-1:0] addr_q;
   logic [2:0]  bp;
   logic [ARRAY_AW-1:0] hi_mask;
   logic        in_range;
   int          k;

   // Armed and configuration are caught on the selecting edge; the
   // configuration inputs must be stable while chip select falls.
   always_ff @(negedge i_cs_b or negedge i_rst_b) begin
      if (!i_rst_b) begin
         armed_q    <= 1'b0;
         cfg_qe_q   <= 1'b0;
         cfg_hsel_q <= 1'b0;
      end else begin
         armed_q    <= 1'b1;
         cfg_qe_q   <= i_quad_enable_bit;
         cfg_hsel_q <= i_hold_reset_sel;
      end
   end

   assign hold_fn = ~cfg_qe_q & ~cfg_hsel_q;
   assign pin_rst = HAS_RESET_PIN ? ~i_reset_pin_b
                  : (~cfg_qe_q & cfg_hsel_q & ~i_lane_in[3]);
   // Deselect or pin reset clears every frame register at once
   assign frame_rst_b = i_rst_b & ~i_cs_b & ~pin_rst;

   // Clock high: keep the state seen at the last falling clock edge
   always_ff @(negedge i_spi_clk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         pause_q <= 1'b0;
      end else begin
         pause_q <= hold_fn & ~i_lane_in[3];
      end
   end
   assign pause = hold_fn & (i_spi_clk ? pause_q : ~i_lane_in[3]);

   // Input lanes shift in at the active width, upper lane first
   always_comb begin
      case (lw_q)
         SFPE_W4: sr_d = {sr_q[3:0], i_lane_in[3:0]};
         SFPE_W2: sr_d = {sr_q[5:0], i_lane_in[1], i_lane_in[0]};
         default: sr_d = {sr_q[6:0], i_lane_in[0]};
      endcase
   end

   assign shifting  = armed_q & ~pause & ((st_q == SFPE_ST_CMD) |
                      (st_q == SFPE_ST_ADDR) | (st_q == SFPE_ST_PASS));
   assign byte_done = shifting & ((bcnt_q + lw_q) == SFPE_BYTE_BITS);
   assign rx_full   = (rx_wp_q == ~rx_rps_q);
   assign rx_push   = byte_done & ~rx_full;

   // Mode 0 and mode 3 both present rising edges for capture only
   always_ff @(posedge i_spi_clk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         st_q   <= SFPE_ST_CMD;
         sr_q   <= 8'h00;
         bcnt_q <= 4'h0;
         lw_q   <= SFPE_W1;
         ow_q   <= SFPE_W1;
         acnt_q <= 2'h0;
         dcnt_q <= 4'h0;
      end else if (!pause) begin
         if (shifting) begin
            sr_q   <= sr_d;
            bcnt_q <= byte_done ? 4'h0 : bcnt_q + lw_q;
         end
         case (st_q)
            SFPE_ST_CMD: begin
               if (!armed_q) begin
                  st_q <= SFPE_ST_IGNORE;
               end else if (byte_done) begin
                  st_q <= SFPE_ST_ADDR;
                  case (sr_d)
                     SFPE_OP_DUAL_OUT: begin
                        ow_q   <= SFPE_W2;
                        dcnt_q <= SFPE_DUMMY_OUT;
                     end
                     SFPE_OP_DUAL_IO: begin
                        lw_q   <= SFPE_W2;
                        ow_q   <= SFPE_W2;
                        dcnt_q <= SFPE_DUMMY_DUAL;
                     end
                     SFPE_OP_QUAD_OUT: begin
                        ow_q   <= SFPE_W4;
                        dcnt_q <= SFPE_DUMMY_OUT;
                        if (!cfg_qe_q) begin
                           st_q <= SFPE_ST_IGNORE;
                        end
                     end
                     SFPE_OP_QUAD_IO: begin
                        lw_q   <= SFPE_W4;
                        ow_q   <= SFPE_W4;
                        dcnt_q <= SFPE_DUMMY_QUAD;
                        if (!cfg_qe_q) begin
                           st_q <= SFPE_ST_IGNORE;
                        end
                     end
                     default: st_q <= SFPE_ST_PASS;
                  endcase
               end
            end
            SFPE_ST_ADDR: begin
               if (byte_done) begin
                  acnt_q <= acnt_q + 2'h1;
                  if (acnt_q == SFPE_ADDR_LAST) begin
                     st_q <= SFPE_ST_DUMMY;
                  end
               end
            end
            SFPE_ST_DUMMY: begin
               dcnt_q <= dcnt_q - 4'h1;
               if (dcnt_q == 4'h1) begin
                  st_q <= SFPE_ST_READ;
               end
            end
            SFPE_ST_READ:   st_q <= SFPE_ST_READ;
            SFPE_ST_PASS:   st_q <= SFPE_ST_PASS;
            SFPE_ST_IGNORE: st_q <= SFPE_ST_IGNORE;
            default:        st_q <= SFPE_ST_IGNORE;
         endcase
      end
   end

   // The master cannot be stalled, so a full mailbox costs a byte
   always_ff @(posedge i_spi_clk) begin
      if (rx_push) begin
         rx_mem_q[rx_wp_q[1] ^ rx_wp_q[0]] <= {st_q == SFPE_ST_CMD, sr_d};
      end
   end

   always_ff @(posedge i_spi_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_wp_q    <= SFPE_PTR_RST;
         ovf_tog_q  <= 1'b0;
         rx_rp_s1_q <= SFPE_PTR_RST;
         rx_rp_s2_q <= SFPE_PTR_RST;
         rx_rp_s3_q <= SFPE_PTR_RST;
         rx_rps_q   <= SFPE_PTR_RST;
      end else begin
         if (rx_push) begin
            rx_wp_q <= sfpe_gray_inc(rx_wp_q);
         end
         if (byte_done && rx_full) begin
            ovf_tog_q <= ~ovf_tog_q;
         end
         rx_rp_s1_q <= rx_rp_q;
         rx_rp_s2_q <= rx_rp_s1_q;
         rx_rp_s3_q <= rx_rp_s2_q;
         if (rx_rp_s2_q == rx_rp_s3_q) begin
            rx_rps_q <= rx_rp_s3_q;
         end
      end
   end

   // Output side: lanes change on falling edges only
   assign drain      = (st_q == SFPE_ST_READ) | (st_q == SFPE_ST_PASS);
   assign tx_empty_l = (tx_wps_q == tx_rp_q);
   assign tx_pop     = drain & ~pause & (ocnt_q == 4'h0) & ~tx_empty_l;

   always_ff @(negedge i_spi_clk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         out_q  <= 4'h0;
         tsr_q  <= 8'h00;
         ocnt_q <= 4'h0;
         oact_q <= 1'b0;
      end else if (drain && !pause) begin
         if (ocnt_q != 4'h0) begin
            out_q  <= sfpe_emit(tsr_q, ow_q);
            tsr_q  <= tsr_q << ow_q;
            ocnt_q <= ocnt_q - ow_q;
         end else if (tx_pop) begin
            out_q  <= sfpe_emit(tx_mem_q[tx_rp_q[1] ^ tx_rp_q[0]], ow_q);
            tsr_q  <= tx_mem_q[tx_rp_q[1] ^ tx_rp_q[0]] << ow_q;
            ocnt_q <= SFPE_BYTE_BITS - ow_q;
            oact_q <= 1'b1;
         end else begin
            oact_q <= 1'b0;
         end
      end
   end

   always_ff @(negedge i_spi_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_rp_q    <= SFPE_PTR_RST;
         tx_wp_s1_q <= SFPE_PTR_RST;
         tx_wp_s2_q <= SFPE_PTR_RST;
         tx_wp_s3_q <= SFPE_PTR_RST;
         tx_wps_q   <= SFPE_PTR_RST;
      end else begin
         if (tx_pop) begin
            tx_rp_q <= sfpe_gray_inc(tx_rp_q);
         end
         tx_wp_s1_q <= tx_wp_q;
         tx_wp_s2_q <= tx_wp_s1_q;
         tx_wp_s3_q <= tx_wp_s2_q;
         if (tx_wp_s2_q == tx_wp_s3_q) begin
            tx_wps_q <= tx_wp_s3_q;
         end
      end
   end

   assign o_lane_out = out_q;
   assign o_lane_oe  = (oact_q & ~pause & ~i_cs_b & frame_rst_b) ?
                       sfpe_lane_en(ow_q) : 4'h0;

   // System side: transmit buffer feeds the transmit mailbox
   sfpe_fifo2 #(.WIDTH(8), .DEPTH(2)) u_tx_buf (
      .i_clk       (i_sys_clk),
      .i_rst_b     (i_rst_b),
      .i_in_valid  (i_tx_valid),
      .o_in_ready  (o_tx_ready),
      .i_in_data   (i_tx_data),
      .o_out_valid (txf_valid),
      .i_out_ready (~tx_full),
      .o_out_data  (txf_data)
   );

   assign tx_full  = (tx_wp_q == ~tx_rps_q);
   assign tx_put   = txf_valid & ~tx_full;
   assign rx_empty = (rx_wps_q == rx_rp_q);
   assign rx_take  = ~rx_empty & rxf_ready;
   assign rx_word  = rx_mem_q[rx_rp_q[1] ^ rx_rp_q[0]];

   always_ff @(posedge i_sys_clk) begin
      if (tx_put) begin
         tx_mem_q[tx_wp_q[1] ^ tx_wp_q[0]] <= txf_data;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_wp_q    <= SFPE_PTR_RST;
         rx_rp_q    <= SFPE_PTR_RST;
         tx_rp_s1_q <= SFPE_PTR_RST;
         tx_rp_s2_q <= SFPE_PTR_RST;
         tx_rp_s3_q <= SFPE_PTR_RST;
         tx_rps_q   <= SFPE_PTR_RST;
         rx_wp_s1_q <= SFPE_PTR_RST;
         rx_wp_s2_q <= SFPE_PTR_RST;
         rx_wp_s3_q <= SFPE_PTR_RST;
         rx_wps_q   <= SFPE_PTR_RST;
      end else begin
         if (tx_put) begin
            tx_wp_q <= sfpe_gray_inc(tx_wp_q);
         end
         if (rx_take) begin
            rx_rp_q <= sfpe_gray_inc(rx_rp_q);
         end
         tx_rp_s1_q <= tx_rp_q;
         tx_rp_s2_q <= tx_rp_s1_q;
         tx_rp_s3_q <= tx_rp_s2_q;
         if (tx_rp_s2_q == tx_rp_s3_q) begin
            tx_rps_q <= tx_rp_s3_q;
         end
         rx_wp_s1_q <= rx_wp_q;
         rx_wp_s2_q <= rx_wp_s1_q;
         rx_wp_s3_q <= rx_wp_s2_q;
         if (rx_wp_s2_q == rx_wp_s3_q) begin
            rx_wps_q <= rx_wp_s3_q;
         end
      end
   end

   // Receive buffer lets the consumer stall without losing held words
   sfpe_fifo2 #(.WIDTH(9), .DEPTH(2)) u_rx_buf (
      .i_clk       (i_sys_clk),
      .i_rst_b     (i_rst_b),
      .i_in_valid  (~rx_empty),
      .o_in_ready  (rxf_ready),
      .i_in_data   (rx_word),
      .o_out_valid (o_rx_valid),
      .i_out_ready (i_rx_ready),
      .o_out_data  (rxf_out)
   );
   assign o_rx_first = rxf_out[8];
   assign o_rx_data  = rxf_out[7:0];

   // Level status bits: a change counts once stages two and three agree
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sy_s1_q <= SFPE_SYNC_RST;
         sy_s2_q <= SFPE_SYNC_RST;
         sy_s3_q <= SFPE_SYNC_RST;
         sy_q    <= SFPE_SYNC_RST;
      end else begin
         sy_s1_q <= {ovf_tog_q, pin_rst, armed_q, i_lane_in[2], i_cs_b};
         sy_s2_q <= sy_s1_q;
         sy_s3_q <= sy_s2_q;
         sy_q    <= (sy_s2_q & sy_s3_q) | (sy_q & (sy_s2_q | sy_s3_q));
      end
   end

   assign o_selected  = ~sy_q[0];
   assign o_armed     = sy_q[2];
   assign o_pin_reset = sy_q[3];
   assign ovf_event   = sy_q[4] ^ ovf_prev_q;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ovf_prev_q <= 1'b0;
         ovr_q      <= 1'b0;
      end else begin
         ovf_prev_q <= sy_q[4];
         // A new overrun wins over a clear in the same cycle
         ovr_q <= ovf_event | (ovr_q & ~i_clear_overrun);
      end
   end
   assign o_rx_overrun = ovr_q;

   // Address of the latest instruction, gathered from the byte stream
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         aidx_q <= 2'h0;
         addr_q <= '0;
      end else if (rx_take) begin
         if (rx_word[8]) begin
            aidx_q <= 2'h1;
         end else if (aidx_q != 2'h0) begin
            addr_q <= {addr_q[ARRAY_AW-9:0], rx_word[7:0]};
            aidx_q <= (aidx_q == 2'h3) ? 2'h0 : aidx_q + 2'h1;
         end
      end
   end

   // Protected span is a power of two at the top or bottom
   assign bp = {i_block_protect_2, i_block_protect_1, i_block_protect_0};
   always_comb begin
      k = 0;
      if (i_protect_sector_granularity) begin
         k = SFPE_SECTOR_AW + ((int'(bp) - 1 > SFPE_SEC_MAX) ?
             SFPE_SEC_MAX : int'(bp) - 1);
      end else begin
         k = ARRAY_AW - SFPE_BP_FULL + int'(bp);
      end
      hi_mask  = {ARRAY_AW{1'b1}} << k;
      in_range = i_protect_top_bottom ? ((addr_q & hi_mask) == '0)
                                      : ((addr_q & hi_mask) == hi_mask);
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         swb_q  <= 1'b0;
         prot_q <= 1'b0;
      end else begin
         // Write-protect pin only counts while lane two is not a data lane
         swb_q  <= (i_status_protect_bits == SFPE_SRP_HW) & ~sy_q[1] &
                   ~i_quad_enable_bit;
         prot_q <= i_protect_complement ^ ((bp != 3'h0) & in_range);
      end
   end
   assign o_status_write_block = swb_q;
   assign o_addr_protected     = prot_q;

endmodule // sfpe_front_end
`default_nettype wire

// file: sfpe_pkg.sv
// Constants, types and helpers shared by the serial flash pin front end
package sfpe_pkg;

   localparam logic [7:0] SFPE_OP_DUAL_OUT = 8'h3B;
   localparam logic [7:0] SFPE_OP_DUAL_IO  = 8'hBB;
   localparam logic [7:0] SFPE_OP_QUAD_OUT = 8'h6B;
   localparam logic [7:0] SFPE_OP_QUAD_IO  = 8'hEB;

   localparam logic [3:0] SFPE_W1 = 4'h1;
   localparam logic [3:0] SFPE_W2 = 4'h2;
   localparam logic [3:0] SFPE_W4 = 4'h4;
   localparam logic [3:0] SFPE_BYTE_BITS = 4'h8;

   localparam logic [1:0] SFPE_ADDR_LAST = 2'h2;
   localparam logic [3:0] SFPE_DUMMY_OUT  = 4'h8;
   localparam logic [3:0] SFPE_DUMMY_DUAL = 4'h4;
   localparam logic [3:0] SFPE_DUMMY_QUAD = 4'h6;

   localparam logic [1:0] SFPE_PTR_RST   = 2'h0;
   localparam logic [4:0] SFPE_SYNC_RST  = 5'h03;
   localparam logic [1:0] SFPE_SRP_HW    = 2'h1;
   localparam int         SFPE_SECTOR_AW = 12;
   localparam int         SFPE_SEC_MAX   = 3;
   localparam int         SFPE_BP_FULL   = 7;

   typedef enum logic [2:0] {
      SFPE_ST_CMD,
      SFPE_ST_ADDR,
      SFPE_ST_DUMMY,
      SFPE_ST_READ,
      SFPE_ST_PASS,
      SFPE_ST_IGNORE
   } sfpe_state_t;

   function automatic logic [1:0] sfpe_gray_inc(input logic [1:0] g);
      case (g)
         2'h0:    sfpe_gray_inc = 2'h1;
         2'h1:    sfpe_gray_inc = 2'h3;
         2'h3:    sfpe_gray_inc = 2'h2;
         default: sfpe_gray_inc = 2'h0;
      endcase
   endfunction

   // Top bits of a byte placed on the lanes for the given width
   function automatic logic [3:0] sfpe_emit(input logic [7:0] d,
                                            input logic [3:0] w);
      case (w)
         SFPE_W4: sfpe_emit = d[7:4];
         SFPE_W2: sfpe_emit = {2'h0, d[7:6]};
         default: sfpe_emit = {2'h0, d[7], 1'b0};
      endcase
   endfunction

   function automatic logic [3:0] sfpe_lane_en(input logic [3:0] w);
      case (w)
         SFPE_W4: sfpe_lane_en = 4'hF;
         SFPE_W2: sfpe_lane_en = 4'h3;
         default: sfpe_lane_en = 4'h2;
      endcase
   endfunction

endpackage

// file: sfpe_fifo2.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sfpe_fifo2
   import sfpe_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_b,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_q != '0);
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;
   assign o_out_data  = mem_q[rd_q];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_q] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + (AW+1)'(1);
         end else if (pop && !push) begin
            cnt_q <= cnt_q - (AW+1)'(1);
         end
      end
   end
endmodule // sfpe_fifo2
`default_nettype wire

// file: sfpe_checker.sv
// Port-level assertions for the serial flash pin front end
`timescale 1ns/1ps
`default_nettype none
module sfpe_checker
   import sfpe_pkg::*;
(
   input wire logic       i_sys_clk,
   input wire logic       i_rst_b,
   input wire logic       i_spi_clk,
   input wire logic       i_cs_b,
   input wire logic [3:0] i_lane_in,
   input wire logic [3:0] o_lane_oe,
   input wire logic       i_quad_enable_bit,
   input wire logic       i_hold_reset_sel,
   input wire logic [1:0] i_status_protect_bits,
   input wire logic       o_selected,
   input wire logic       o_armed,
   input wire logic       o_rx_valid,
   input wire logic       i_rx_ready,
   input wire logic [7:0] o_rx_data,
   input wire logic       o_status_write_block
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   a_desel_float: assert property (
      i_cs_b |-> o_lane_oe == 4'h0) else $error("drive while deselected");
   a_sel_follow: assert property (
      $stable(i_cs_b) [*6] |-> o_selected == !i_cs_b)
      else $error("selected lags chip select");
   a_rx_armed: assert property (
      o_rx_valid |-> o_armed) else $error("byte before arming");
   a_lane_width: assert property (
      o_lane_oe inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("bad lane set");
   // Pause acts at once while the clock is low, so no grace cycle here
   a_pause_float: assert property (
      !i_cs_b && !i_spi_clk && !i_lane_in[3] && !i_quad_enable_bit &&
      !i_hold_reset_sel |-> o_lane_oe == 4'h0) else $error("drive in pause");
   a_wp_block: assert property (
      (i_status_protect_bits == SFPE_SRP_HW && !i_lane_in[2] &&
      !i_quad_enable_bit) [*6] |-> o_status_write_block)
      else $error("status write not blocked");
   a_quad_nowp: assert property (
      i_quad_enable_bit |=> !o_status_write_block) else $error("wp in quad");
   a_rx_stall_hold: assert property (o_rx_valid && !i_rx_ready |=>
      o_rx_valid && $stable(o_rx_data)) else $error("stalled byte lost");
   c_rx_take: cover property (o_rx_valid && i_rx_ready);
   c_dual_out: cover property (o_lane_oe == 4'h3);
   c_wp_block: cover property (o_status_write_block);
endmodule // sfpe_checker
`default_nettype wire

// file: sfpe_mst.sv
// Serial bus master model driving the front end pins
`timescale 1ns/1ps
`default_nettype none
module sfpe_mst (
   output logic            o_spi_clk = 1'b0,
   output logic            o_cs_b = 1'b1,
   output logic [3:0]      o_lane,
   input  wire logic [3:0] i_out,
   input  wire logic [3:0] i_oe
);
   logic [3:0] drv = 4'hC;
   logic [3:0] rel = 4'h0;
   logic       idle = 1'b0;
   // Released lanes read inverted, so a stale level can never pass
   assign o_lane = (i_oe & i_out) | (~i_oe & (drv ^ rel));
   task automatic start(input logic m);
      idle = m;
      o_spi_clk = m;
      #20 o_cs_b = 1'b0;
      #20;
   endtask
   task automatic stop;
      #8 o_spi_clk = idle;
      #20 o_cs_b = 1'b1;
      rel = 4'h0;
      #60;
   endtask
   // Clock stands still between calls; gives the crossings time
   task automatic xfer(input int w, n, input logic rd,
                       input logic [7:0] d, output logic [7:0] q);
      q = 8'h00;
      rel[1:0] = {2{rd}};
      for (int i = 0; i < n; i++) begin
         o_spi_clk = 1'b0;
         for (int k = 0; k < w; k++) drv[k] = d[8 - w + k];
         d = d << w;
         #7.5 o_spi_clk = 1'b1;
         q = q << w;
         for (int k = 0; k < w; k++) q[k] = o_lane[w == 1 ? 1 : k];
         #7.5;
      end
      #100;
   endtask
endmodule // sfpe_mst
`default_nettype wire

// file: sfpe_front_end_bench.sv
// Self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
`default_nettype none
module sfpe_front_end_bench
   import sfpe_pkg::*;
;
   logic i_sys_clk = 0, i_rst_b = 0, i_quad_enable_bit = 0, i_tx_valid = 0;
   logic i_hold_reset_sel = 0, i_rx_ready = 1, i_clear_overrun = 0;
   logic i_reset_pin_b = 1, i_block_protect_2 = 0, i_block_protect_1 = 0;
   logic i_block_protect_0 = 0, i_protect_top_bottom = 0;
   logic i_protect_sector_granularity = 0, i_protect_complement = 0;
   logic i_spi_clk, i_cs_b, o_tx_ready, o_rx_valid, o_rx_first, o_selected;
   logic o_armed, o_pin_reset, o_rx_overrun, o_status_write_block;
   logic o_addr_protected;
   logic [1:0] i_status_protect_bits = 0;
   logic [3:0] i_lane_in, o_lane_out, o_lane_oe;
   logic [7:0] i_tx_data = 0, o_rx_data, q;
   logic [8:0] rxq [$];
   int         error_cnt = 0, n_tests = 0;
   sfpe_front_end i_sfpe_front_end (.*);
   sfpe_mst i_sfpe_mst (.o_spi_clk(i_spi_clk), .o_cs_b(i_cs_b),
      .o_lane(i_lane_in), .i_out(o_lane_out), .i_oe(o_lane_oe));
   always #20 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) if (o_rx_valid && i_rx_ready)
      rxq.push_back({o_rx_first, o_rx_data});
   task automatic give_verdict;
      if (error_cnt == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [8:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wclk(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask
   task automatic sb(input logic [7:0] d);
      i_sfpe_mst.xfer(1, 8, 1'b0, d, q);
   endtask
   // Always returns on a falling edge so later inputs stay off the sample
   task automatic getrx(input logic [8:0] exp);
      wclk(1);
      for (int i = 0; i < 80 && rxq.size() == 0; i++) wclk(1);
      if (rxq.size() == 0) begin
         chk(~exp, exp);
         give_verdict();
      end else begin
         chk(rxq.pop_front(), exp);
      end
   endtask
   // Valid stays up across pushes; the caller drops it once
   task automatic push(input logic [7:0] d);
      i_tx_valid = 1'b1;
      i_tx_data = d;
      for (int i = 0; i < 50 && o_tx_ready !== 1'b1; i++) wclk(1);
      if (o_tx_ready !== 1'b1) begin
         chk(9'h000, 9'h001);
         give_verdict();
      end else begin
         wclk(1);
      end
   endtask
   initial begin
      wclk(12);
      i_rst_b = 1'b1;
      wclk(2);
      chk({o_armed, o_selected, o_tx_ready, o_lane_oe}, 9'h010);
      i_sfpe_mst.start(1'b0);
      i_sfpe_mst.xfer(1, 4, 1'b0, 8'hF0, q);
      i_sfpe_mst.stop();
      wclk(1);
      for (int m = 0; m < 2; m++) begin
         for (int b = 0; b < 4; b++) push(8'hD0 + b[7:0]);
         i_tx_valid = 1'b0;
         wclk(2);
         chk({8'h00, o_tx_ready}, 9'h000);
         i_sfpe_mst.start(m[0]);
         sb(8'h05);
         for (int b = 0; b < 4; b++) begin
            sb(8'hA5);
            chk({1'b0, q}, {5'h0D, b[3:0]});
         end
         i_sfpe_mst.stop();
         getrx(9'h105);
         for (int b = 0; b < 4; b++) getrx(9'h0A5);
      end
      chk({8'h00, o_armed}, 9'h001);
      push(8'h96);
      i_tx_valid = 1'b0;
      i_sfpe_mst.start(1'b0);
      sb(SFPE_OP_DUAL_OUT);
      repeat (4) sb(8'h00);
      i_sfpe_mst.xfer(2, 4, 1'b1, 8'h00, q);
      chk({1'b0, q}, 9'h096);
      i_sfpe_mst.stop();
      getrx({1'b1, SFPE_OP_DUAL_OUT});
      wclk(40);
      rxq.delete();
      i_sfpe_mst.start(1'b0);
      sb(8'h05);
      i_sfpe_mst.xfer(1, 4, 1'b0, 8'hC3, q);
      i_sfpe_mst.drv[3] = 1'b0;
      // Eight paused clocks: some system edge must see the clock low
      i_sfpe_mst.xfer(1, 8, 1'b0, 8'hFF, q);
      i_sfpe_mst.drv[3] = 1'b1;
      i_sfpe_mst.xfer(1, 4, 1'b0, 8'h30, q);
      i_sfpe_mst.stop();
      getrx(9'h105);
      getrx(9'h0C3);
      i_status_protect_bits = SFPE_SRP_HW;
      i_block_protect_0 = 1'b1;
      i_protect_complement = 1'b1;
      i_sfpe_mst.drv[2] = 1'b0;
      wclk(8);
      chk({7'h00, o_status_write_block, o_addr_protected}, 9'h003);
      i_quad_enable_bit = 1'b1;
      i_protect_top_bottom = 1'b1;
      wclk(2);
      chk({7'h00, o_status_write_block, o_addr_protected}, 9'h000);
      i_quad_enable_bit = 1'b0;
      i_rx_ready = 1'b0;
      i_sfpe_mst.start(1'b0);
      for (int b = 0; b < 6; b++) sb(8'h11 * b[7:0]);
      i_sfpe_mst.stop();
      wclk(20);
      chk({8'h00, o_rx_overrun}, 9'h001);
      i_rx_ready = 1'b1;
      for (int b = 0; b < 4; b++) getrx({b == 0, 8'h11 * b[7:0]});
      i_clear_overrun = 1'b1;
      wclk(1);
      i_clear_overrun = 1'b0;
      wclk(2);
      chk({8'h00, o_rx_overrun}, 9'h000);
      i_hold_reset_sel = 1'b1;
      i_sfpe_mst.start(1'b0);
      i_sfpe_mst.drv[3] = 1'b0;
      sb(8'h05);
      wclk(8);
      chk({8'h00, o_pin_reset}, 9'h001);
      i_sfpe_mst.drv[3] = 1'b1;
      i_sfpe_mst.stop();
      wclk(1);
      i_hold_reset_sel = 1'b0;
      i_sfpe_mst.start(1'b0);
      sb(SFPE_OP_QUAD_OUT);
      sb(8'h5A);
      i_sfpe_mst.stop();
      getrx({1'b1, SFPE_OP_QUAD_OUT});
      wclk(40);
      chk({o_pin_reset, 8'(rxq.size())}, 9'h000);
      give_verdict();
   end
endmodule // sfpe_front_end_bench
bind sfpe_front_end sfpe_checker i_sfpe_checker (.*);
`default_nettype wire
